/* File: rtl/wesi_map.svh */
/*
  Offsets, field positions, reset values and timing figures of the
  wake event status and indicator block.
  Assumes a 100 MHz core clock and an 8-bit host byte address.
*/
`ifndef WESI_MAP_SVH
`define WESI_MAP_SVH

// register offset on the host bus
`define WESI_PEC_OFFSET 8'h84

// field positions inside power_event_control
`define WESI_READY_BIT 0
`define WESI_OUT_EN_BIT 1
`define WESI_POL_BIT 2
`define WESI_PULSE_BIT 3
`define WESI_CAUSE_LO 4
`define WESI_CAUSE_HI 5

// reset values
`define WESI_CAUSE_RST 2'h0
`define WESI_CTRL_RST 1'h0

// timing
`define WESI_CLK_MHZ 100
`define WESI_PULSE_MS 50
`define WESI_PULSE_CYCLES (`WESI_PULSE_MS * 1000 * `WESI_CLK_MHZ)
`define WESI_STABLE_US 1
`define WESI_STABLE_CYCLES (`WESI_STABLE_US * `WESI_CLK_MHZ)

`endif

/* File: rtl/wesi_pkg.sv */
/*
  Types shared by the wake event status and indicator block.
  Assumes wesi_map.svh is on the include path.
*/
package wesi_pkg;
  // power state encoding, driven by the neighbouring mode logic
  typedef enum logic [1:0] {
    WESI_FULL_POWER = 2'h0,
    WESI_FRAME_WAKE = 2'h1,
    WESI_ENERGY_WAKE = 2'h2,
    WESI_STATE_RSVD = 2'h3
  } wesi_power_e;

  // wake cause codes as read by the host
  typedef logic [1:0] wesi_cause_t;
  localparam wesi_cause_t WESI_CAUSE_NONE = 2'h0;
  localparam wesi_cause_t WESI_CAUSE_ENERGY = 2'h1;
  localparam wesi_cause_t WESI_CAUSE_FRAME = 2'h2;
  localparam wesi_cause_t WESI_CAUSE_MULTI = 2'h3;

  // readiness sequencing
  typedef enum {
    WESI_ASLEEP,
    WESI_SETTLING,
    WESI_READY
  } wesi_ready_e;
endpackage

/* File: rtl/wesi_power_event.sv */
/*
  Wake event status, power event pin and ready flag: the low half of
  power_event_control, reached over the SRAM-like host bus.
  Assumes synchronous active-low host strobes, one host, and that the
  power state, wake enables and pin buffer kind come from neighbouring
  logic holding the upper half of the register.
*/
// Operation
// - wake cause reads 00 none, 01 energy, 10 frame, 11 multiple.
// - writing 1 to a cause bit clears it; writing 0 keeps it.
// - cause bits clear only at full power with ready set.
// - a cause bit stays set while its event source is pending.
// - pulse mode drives the event pin active for 50 ms per event.
// - static mode holds the event pin active from detection on.
// - event pin drops when causes or the matching enable clear.
// - push-pull pin is active high when polarity 1, low when 0.
// - open-drain pin ignores polarity and is always active low.
// - event pin is driven only while the output enable is set.
// - output enable has no effect on the power event interrupt.
// - read-only ready flag sets once stable after power-up or wake.
// - this register reads correctly in every power state.
// - power state 00 full, 01 frame wake, 10 energy wake, 11 reserved.
// - an enabled lan wake raises the interrupt regardless of pin enable.
// - in reduced power a byte-test write wakes the device.
`timescale 1ns/10ps
`include "wesi_map.svh"
module wesi_power_event
  import wesi_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PULSE_CYCLES = `WESI_PULSE_CYCLES,
  parameter int STABLE_CYCLES = `WESI_STABLE_CYCLES,
  parameter logic [7:0] BYTE_TEST_ADDR = 8'h00
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // host bus
  input wire logic hostCs_n,
  input wire logic hostRd_n,
  input wire logic hostWr_n,
  input wire logic [ADDR_W-1:0] hostAddr,
  input wire logic [31:0] hostWrData,
  output logic [31:0] hostRdData,
  // neighbouring control fields
  input wire logic [1:0] powerStateSelect,
  input wire logic lanWakeEnable,
  input wire logic energyWakeEnable,
  input wire logic eventOutputBufferKind,
  // wake event sources
  input wire logic energyEvent,
  input wire logic lanWakeEvent,
  input wire logic energyPending,
  input wire logic lanWakePending,
  // event pin and interrupt
  output logic powerEventOutput,
  output logic powerEventOutputOe,
  output logic powerEventInterrupt,
  // wake request to the power state logic
  output logic wakeRequest
);
  localparam int PULSE_W = $clog2(PULSE_CYCLES + 1);
  localparam int STABLE_W = $clog2(STABLE_CYCLES + 1);

  // refused at elaboration: byte decode and counters assume these
  if (ADDR_W != 8) begin
    $error("wesi_power_event: ADDR_W must be 8");
  end
  if (PULSE_CYCLES < 1 || STABLE_CYCLES < 1) begin
    $error("wesi_power_event: cycle counts must be at least 1");
  end

  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] target);
    hits = (addr == target);
  endfunction

  // host access decode
  logic hostRead;
  logic hostWrite;
  logic pecRead;
  logic pecWrite;
  assign hostRead = !hostCs_n && !hostRd_n;
  assign hostWrite = !hostCs_n && !hostWr_n;
  assign pecRead = hostRead && hits(hostAddr, `WESI_PEC_OFFSET);
  assign pecWrite = hostWrite && hits(hostAddr, `WESI_PEC_OFFSET);

  // ready sequencing
  wesi_ready_e readyState;
  wesi_ready_e next_readyState;
  logic [STABLE_W-1:0] settleCount;
  logic [STABLE_W-1:0] next_settleCount;
  logic ready;
  logic fullPower;
  assign fullPower = (wesi_power_e'(powerStateSelect) == WESI_FULL_POWER);
  assign ready = (readyState == WESI_READY);

  always_comb begin
    next_readyState = readyState;
    next_settleCount = settleCount;
    unique case (readyState)
      WESI_ASLEEP: begin
        if (fullPower) begin
          next_readyState = WESI_SETTLING;
          next_settleCount = STABLE_W'(STABLE_CYCLES);
        end
      end
      WESI_SETTLING: begin
        if (!fullPower) begin
          next_readyState = WESI_ASLEEP;
        end else if (settleCount <= STABLE_W'(1)) begin
          next_readyState = WESI_READY;
          next_settleCount = '0;
        end else begin
          next_settleCount = settleCount - STABLE_W'(1);
        end
      end
      WESI_READY: begin
        if (!fullPower) begin
          next_readyState = WESI_ASLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      readyState <= WESI_SETTLING;
      settleCount <= STABLE_W'(STABLE_CYCLES);
    end else begin
      readyState <= next_readyState;
      settleCount <= next_settleCount;
    end
  end

  // software controls and wake cause
  logic pulseSelect;
  logic polarity;
  logic outEnable;
  wesi_cause_t wakeCause;
  logic next_pulseSelect;
  logic next_polarity;
  logic next_outEnable;
  wesi_cause_t next_wakeCause;
  wesi_cause_t newCause;
  wesi_cause_t clearMask;
  wesi_cause_t holdMask;
  logic wakeDetect;

  // bit 0 tracks energy, bit 1 tracks frame, both set reads as multiple
  assign newCause = {lanWakeEvent && lanWakeEnable, energyEvent && energyWakeEnable};
  assign holdMask = {lanWakePending, energyPending};
  assign wakeDetect = (newCause != WESI_CAUSE_NONE);

  always_comb begin
    next_pulseSelect = pulseSelect;
    next_polarity = polarity;
    next_outEnable = outEnable;
    clearMask = WESI_CAUSE_NONE;
    if (pecWrite) begin
      next_pulseSelect = hostWrData[`WESI_PULSE_BIT];
      next_polarity = hostWrData[`WESI_POL_BIT];
      next_outEnable = hostWrData[`WESI_OUT_EN_BIT];
      if (ready) begin
        clearMask = hostWrData[`WESI_CAUSE_HI:`WESI_CAUSE_LO];
      end
    end
    // pending sources block clearing; new events win over the clear
    // one bit per type, so a second event of the other type ORs up to 11
    // and a clear of the other bit is not lost to it
    next_wakeCause = (wakeCause & ~(clearMask & ~holdMask)) | newCause;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pulseSelect <= `WESI_CTRL_RST;
      polarity <= `WESI_CTRL_RST;
      outEnable <= `WESI_CTRL_RST;
      wakeCause <= `WESI_CAUSE_RST;
    end else begin
      pulseSelect <= next_pulseSelect;
      polarity <= next_polarity;
      outEnable <= next_outEnable;
      wakeCause <= next_wakeCause;
    end
  end

  // pulse timing
  logic pulseBusy;
  logic causeLive;
  assign causeLive = (wakeCause[0] && energyWakeEnable) || (wakeCause[1] && lanWakeEnable);

  wesi_pulse_timer #(
    .WIDTH(PULSE_W),
    .COUNT(PULSE_CYCLES)
  ) pulseTimer (
    .core_clk(core_clk),
    .reset(reset),
    .start(wakeDetect),
    .abort(!causeLive),
    .busy(pulseBusy)
  );

  // pin and interrupt generation
  logic eventActive;
  logic next_pinOut;
  logic next_pinOe;
  logic next_interrupt;
  logic next_wakeRequest;
  logic [31:0] next_rdData;

  always_comb begin
    // pulse mode ends after the timer, static mode holds with the cause
    eventActive = causeLive && (pulseSelect ? pulseBusy : 1'b1);
    if (!eventOutputBufferKind) begin
      // open-drain: pull low when active, release otherwise
      next_pinOut = 1'b0;
      next_pinOe = outEnable && eventActive;
    end else begin
      next_pinOut = polarity ? eventActive : !eventActive;
      next_pinOe = outEnable;
    end
    next_interrupt = causeLive;
    next_wakeRequest = !fullPower && hostWrite && hits(hostAddr, BYTE_TEST_ADDR);
    next_rdData = 32'h0;
    // decode ignores the power state so reads work while asleep
    if (pecRead) begin
      next_rdData[`WESI_CAUSE_HI:`WESI_CAUSE_LO] = wakeCause;
      next_rdData[`WESI_PULSE_BIT] = pulseSelect;
      next_rdData[`WESI_POL_BIT] = polarity;
      next_rdData[`WESI_OUT_EN_BIT] = outEnable;
      next_rdData[`WESI_READY_BIT] = ready;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      powerEventOutput <= 1'b0;
      powerEventOutputOe <= 1'b0;
      powerEventInterrupt <= 1'b0;
      wakeRequest <= 1'b0;
      hostRdData <= 32'h0;
    end else begin
      powerEventOutput <= next_pinOut;
      powerEventOutputOe <= next_pinOe;
      powerEventInterrupt <= next_interrupt;
      wakeRequest <= next_wakeRequest;
      hostRdData <= next_rdData;
    end
  end
endmodule

/* File: rtl/wesi_pulse_timer.sv */
/*
  Retriggerable one-shot timer: busy for COUNT cycles after start.
  Assumes start and abort are synchronous single-cycle or level inputs.
*/
`timescale 1ns/10ps
module wesi_pulse_timer
  import wesi_pkg::*;
#(
  parameter int WIDTH = 23,
  parameter int COUNT = 5000000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic start,
  input wire logic abort,
  // status
  output logic busy
);
  // refused at elaboration: a count the counter cannot hold
  if (COUNT < 1 || COUNT >= (64'h1 << WIDTH)) begin
    $error("wesi_pulse_timer: COUNT does not fit WIDTH");
  end

  logic [WIDTH-1:0] remaining;
  logic [WIDTH-1:0] next_remaining;

  always_comb begin
    next_remaining = remaining;
    if (start) begin
      // restart wins so that a fresh event always gets a full pulse
      next_remaining = WIDTH'(COUNT);
    end else if (abort) begin
      next_remaining = '0;
    end else if (remaining != '0) begin
      next_remaining = remaining - WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      remaining <= '0;
    end else begin
      remaining <= next_remaining;
    end
  end

  assign busy = (remaining != '0);
endmodule

/* File: testbench/tb.sv */
/*
  Self-checking bench for wesi_power_event driven by the host model.
  Assumes shortened pulse and settle counts set at the instance.
*/
`timescale 1ns/10ps
`include "wesi_map.svh"
module tb
  import wesi_pkg::*;
;
  localparam int PULSE = 20;
  localparam logic [7:0] PEC = `WESI_PEC_OFFSET;
  typedef struct packed {logic kind, pol, en, lan, out, oe;} wesi_row_s;
  // kind pol en lan : out oe while active
  wesi_row_s rows[5] = '{6'b111011, 6'b101101, 6'b011001, 6'b001101, 6'b110010};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hostCs_n, hostRd_n, hostWr_n;
  logic [7:0] hostAddr;
  logic [31:0] hostWrData, hostRdData, d;
  logic [1:0] powerStateSelect = 2'h0;
  logic lanWakeEnable = 1'b1, energyWakeEnable = 1'b1, eventOutputBufferKind = 1'b1;
  logic energyEvent = 1'b0, lanWakeEvent = 1'b0, energyPending = 1'b0, lanWakePending = 1'b0;
  logic powerEventOutput, powerEventOutputOe, powerEventInterrupt, wakeRequest;
  int n_mismatch = 0, checks = 0, ticks = 0, n;
  initial forever #5 core_clk = ~core_clk;
  wesi_power_event #(.PULSE_CYCLES(PULSE), .STABLE_CYCLES(4)) u_dut (.core_clk, .reset,
    .hostCs_n, .hostRd_n, .hostWr_n, .hostAddr, .hostWrData, .hostRdData, .powerStateSelect,
    .lanWakeEnable, .energyWakeEnable, .eventOutputBufferKind, .energyEvent, .lanWakeEvent,
    .energyPending, .lanWakePending, .powerEventOutput, .powerEventOutputOe,
    .powerEventInterrupt, .wakeRequest);
  wesi_host_model u_host (.core_clk, .hostRdData, .hostCs_n, .hostRd_n, .hostWr_n,
    .hostAddr, .hostWrData);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] v);
    u_host.cyc(1'b1, PEC, v);
  endtask
  task automatic rdc(input logic [31:0] e, input string w);
    u_host.rd(PEC, d);
    chk(d, e, w);
  endtask
  // returns two edges after the event was sampled, pin already moved
  task automatic fire(input logic e, input logic l);
    @(posedge core_clk);
    energyEvent <= e;
    lanWakeEvent <= l;
    @(posedge core_clk);
    energyEvent <= 1'b0;
    lanWakeEvent <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // starts two active edges into a pulse and counts the first low edge too,
  // so the pulse length is one more than c
  task automatic plen(output int c);
    c = 0;
    while (powerEventOutput === 1'b1 && c < 100) begin
      @(posedge core_clk);
      #1;
      c++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    ticks++;
    if (ticks == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    // push-pull with polarity 0 idles high, but is not driven
    chk({28'h0, powerEventOutput, powerEventOutputOe, powerEventInterrupt, wakeRequest},
      32'h8, "reset outputs");
    u_host.wait_ready(d);
    chk(d, 32'h1, "reset value");
    u_host.rd(8'h88, d);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge core_clk);
      eventOutputBufferKind <= rows[i].kind;
      wr({28'h0, 1'b0, rows[i].pol, rows[i].en, 1'b0});
      fire(!rows[i].lan, rows[i].lan);
      chk({29'h0, powerEventOutput, powerEventOutputOe, powerEventInterrupt},
        {29'h0, rows[i].out, rows[i].oe, 1'b1}, "active pin");
      rdc({26'h0, rows[i].lan ? WESI_CAUSE_FRAME : WESI_CAUSE_ENERGY, 1'b0, rows[i].pol,
        rows[i].en, 1'b1}, "cause");
      wr({26'h0, 2'h3, 1'b0, rows[i].pol, rows[i].en, 1'b0});
      @(posedge core_clk);
      #1;
      chk({29'h0, powerEventOutput, powerEventOutputOe, powerEventInterrupt},
        {29'h0, rows[i].kind & !rows[i].pol, rows[i].kind & rows[i].en, 1'b0},
        "idle pin");
      $display("test row %0d done", i);
    end
    fire(1'b1, 1'b0);
    fire(1'b0, 1'b1);
    wr(32'h0);
    rdc(32'h31, "multiple kept");
    @(posedge core_clk);
    energyPending <= 1'b1;
    wr(32'h30);
    rdc(32'h11, "pending held");
    // sources go quiet before the status is cleared
    @(posedge core_clk);
    energyPending <= 1'b0;
    wr(32'h10);
    rdc(32'h1, "cleared");
    $display("test multiple done");
    wr(32'hE);
    fire(1'b1, 1'b0);
    plen(n);
    chk(n + 1, PULSE, "pulse length");
    fire(1'b1, 1'b0);
    repeat (5) @(posedge core_clk);
    fire(1'b1, 1'b0);
    plen(n);
    chk(n + 1, PULSE, "restart length");
    wr(32'h16);
    fire(1'b1, 1'b0);
    repeat (30) @(posedge core_clk);
    #1;
    chk({29'h0, powerEventOutput, powerEventOutputOe, powerEventInterrupt}, 32'h7,
      "static pin");
    @(posedge core_clk);
    {energyWakeEnable, lanWakeEnable} <= 2'h0;
    repeat (3) @(posedge core_clk);
    #1;
    chk({29'h0, powerEventOutput, powerEventOutputOe, powerEventInterrupt}, 32'h2,
      "enable dropped");
    @(posedge core_clk);
    {energyWakeEnable, lanWakeEnable} <= 2'h3;
    wr(32'h10);
    $display("test pulse done");
    @(posedge core_clk);
    powerStateSelect <= 2'h1;
    fire(1'b0, 1'b1);
    wr(32'h20);
    rdc(32'h20, "asleep");
    u_host.cyc(1'b1, 8'h00, 32'h0);
    chk({31'h0, wakeRequest}, 32'h1, "wake");
    @(posedge core_clk);
    powerStateSelect <= 2'h0;
    u_host.wait_ready(d);
    chk(d, 32'h21, "awake");
    wr(32'h20);
    rdc(32'h1, "clear awake");
    $display("test sleep done");
    final_report();
  end
endmodule
bind wesi_power_event wesi_power_event_asserts #(.ADDR_W(ADDR_W),
  .BYTE_TEST_ADDR(BYTE_TEST_ADDR)) u_chk (.core_clk, .reset, .hostCs_n, .hostRd_n,
  .hostWr_n, .hostAddr, .hostRdData, .powerStateSelect, .lanWakeEnable, .energyWakeEnable,
  .eventOutputBufferKind, .energyEvent, .powerEventOutput, .powerEventOutputOe,
  .powerEventInterrupt, .wakeRequest);

/* File: testbench/wesi_host_model.sv */
/*
  Host processor on the SRAM-like bus.
  Assumes one bench process calls its tasks at a time.
*/
`timescale 1ns/10ps
module wesi_host_model (
  // clock and read data
  input wire logic core_clk,
  input wire logic [31:0] hostRdData,
  // strobes, address and data
  output logic hostCs_n,
  output logic hostRd_n,
  output logic hostWr_n,
  output logic [7:0] hostAddr,
  output logic [31:0] hostWrData
);
  initial begin
    {hostCs_n, hostRd_n, hostWr_n} = 3'h7;
    hostAddr = 8'h00;
    hostWrData = 32'h0;
  end
  task automatic cyc(input logic wr, input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    hostCs_n <= 1'b0;
    hostRd_n <= wr;
    hostWr_n <= !wr;
    hostAddr <= a;
    hostWrData <= v;
    @(posedge core_clk);
    // released lines show the inverse so stale values cannot pass
    {hostCs_n, hostRd_n, hostWr_n} <= 3'h7;
    hostAddr <= ~a;
    hostWrData <= ~v;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    cyc(1'b0, a, 32'h0);
    v = hostRdData;
  endtask
  // nothing else is touched until ready reads set or 40 reads have passed
  task automatic wait_ready(output logic [31:0] v);
    v = 32'h0;
    for (int i = 0; i < 40 && v[0] !== 1'b1; i++) rd(8'h84, v);
  endtask
endmodule

/* File: testbench/wesi_power_event_asserts.sv */
/*
  Port checker for wesi_power_event.
  Assumes it is bound to the design from the bench top file.
*/
`timescale 1ns/10ps
`include "wesi_map.svh"
module wesi_power_event_asserts
  import wesi_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [7:0] BYTE_TEST_ADDR = 8'h00
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // host bus
  input wire logic hostCs_n,
  input wire logic hostRd_n,
  input wire logic hostWr_n,
  input wire logic [ADDR_W-1:0] hostAddr,
  input wire logic [31:0] hostRdData,
  // control fields and events
  input wire logic [1:0] powerStateSelect,
  input wire logic lanWakeEnable,
  input wire logic energyWakeEnable,
  input wire logic eventOutputBufferKind,
  input wire logic energyEvent,
  // pin, interrupt and wake
  input wire logic powerEventOutput,
  input wire logic powerEventOutputOe,
  input wire logic powerEventInterrupt,
  input wire logic wakeRequest
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic rdReg;
  logic wakeCause;
  assign rdReg = !hostCs_n && !hostRd_n && hostAddr == `WESI_PEC_OFFSET;
  assign wakeCause = !hostCs_n && !hostWr_n && hostAddr == BYTE_TEST_ADDR
    && powerStateSelect != 2'h0;
  read_idle_a:
    assert property (!rdReg |=> hostRdData == 32'h0) else $error("read data not idle");
  ready_low_a:
    assert property ((powerStateSelect != 2'h0)[*3] ##0 rdReg |=> !hostRdData[0])
      else $error("ready set while asleep");
  ready_set_a:
    assert property ((powerStateSelect == 2'h0)[*8] ##0 rdReg |=> hostRdData[0])
      else $error("ready not set");
  wake_req_a:
    assert property (wakeCause |=> wakeRequest) else $error("no wake request");
  wake_only_a:
    assert property (wakeRequest |-> $past(wakeCause)) else $error("stray wake request");
  energy_irq_a:
    assert property (energyEvent && energyWakeEnable ##1 energyWakeEnable
      |=> powerEventInterrupt) else $error("no interrupt");
  irq_quiet_a:
    assert property (!lanWakeEnable && !energyWakeEnable |=> !powerEventInterrupt)
      else $error("interrupt without enable");
  drain_low_a:
    assert property (!eventOutputBufferKind && $past(eventOutputBufferKind) == 1'b0
      && powerEventOutputOe |-> !powerEventOutput) else $error("open drain pin high");
endmodule
